/* File: hw/cso_pkg.sv */
`default_nettype none
package cso_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0]  CSO_CTRL_IDX      = 6'h0d;
	localparam logic [5:0]  CSO_STAT_IDX      = 6'h0e;
	localparam int          CSO_RX_EN_BIT     = 0;
	localparam int          CSO_RX_MODE_BIT   = 1;
	localparam int          CSO_TX_EN_BIT     = 16;
	localparam int          CSO_RX_BUSY_BIT   = 0;
	localparam int          CSO_TX_BUSY_BIT   = 1;
	localparam logic        CSO_EN_RESET      = 1'b0;
	localparam logic        CSO_MODE_RESET    = 1'b0;
	localparam logic [31:0] CSO_READ_UNMAPPED = 32'h0000_0000;

	// Frame layout
	localparam logic [3:0]  CSO_ADDR_BYTES    = 4'hc;
	localparam logic [3:0]  CSO_HDR_BYTES     = 4'he;
	localparam logic [3:0]  CSO_TAG_BYTES     = 4'h2;
	localparam logic [3:0]  CSO_SNAP_BYTES    = 4'h8;
	localparam logic [15:0] CSO_TYPE_VLAN     = 16'h8100;
	localparam logic [15:0] CSO_TYPE_QINQ     = 16'h88a8;
	localparam logic [15:0] CSO_MAX_LENGTH    = 16'h05dc;
	localparam logic [7:0]  CSO_LLC_SAP       = 8'haa;
	localparam logic [7:0]  CSO_LLC_CTRL      = 8'h03;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic [7:0] data;
	} cso_byte_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] sum;
	} cso_csum_s;

	// One's complement sum with end-around carry
	function automatic logic [15:0] cso_add16(input logic [15:0] a,
		input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// Even byte offsets are the high byte of a 16-bit word
	function automatic logic [15:0] cso_add_byte(input logic [15:0] acc,
		input logic odd, input logic [7:0] b);
		return cso_add16(acc, odd ? {8'h00, b} : {b, 8'h00});
	endfunction
endpackage
`default_nettype wire

/* File: hw/cso_checksum_offload_control.sv */
// The Avalon-MM register port was left to the implementer.
`default_nettype none
module cso_checksum_offload_control
	import cso_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire cso_byte_s   rx_in,
	output cso_byte_s        rx_out,
	output cso_csum_s        rx_csum,
	input  wire cso_byte_s   tx_in,
	output cso_byte_s        tx_out,
	output cso_csum_s        tx_csum
);

	// Header walk for the receive start finder
	typedef enum {
		RX_IDLE,
		RX_ADDR,
		RX_TYPE_HI,
		RX_TYPE_LO,
		RX_TAG,
		RX_SNAP,
		RX_SUM
	} cso_rx_e;

	// Register bank
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rx_en_q, rx_en_d;
	logic        rx_mode_q, rx_mode_d;
	logic        tx_en_q, tx_en_d;
	logic        hit_ctrl, hit_stat;
	logic [31:0] ctrl_view, stat_view;

	// Receive engine
	cso_rx_e     rx_st_q, rx_st_d;
	logic [3:0]  rx_cnt_q, rx_cnt_d;
	logic [7:0]  rx_hi_q, rx_hi_d;
	logic [15:0] rx_acc_q, rx_acc_d;
	logic        rx_odd_q, rx_odd_d;
	logic        rx_snap_q, rx_snap_d;
	cso_byte_s   rx_out_q;
	cso_csum_s   rx_csum_q, rx_csum_d;

	// Transmit engine
	logic        tx_act_q, tx_act_d;
	logic [3:0]  tx_cnt_q, tx_cnt_d;
	logic [15:0] tx_acc_q, tx_acc_d;
	logic        tx_odd_q, tx_odd_d;
	cso_byte_s   tx_out_q;
	cso_csum_s   tx_csum_q, tx_csum_d;

	assign hit_ctrl = avs_address[7:2] == CSO_CTRL_IDX;
	assign hit_stat = avs_address[7:2] == CSO_STAT_IDX;

	// Status view lets software wait for idle paths before a change
	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[CSO_RX_EN_BIT] = rx_en_q;
		ctrl_view[CSO_RX_MODE_BIT] = rx_mode_q;
		ctrl_view[CSO_TX_EN_BIT] = tx_en_q;
		stat_view = 32'h0000_0000;
		stat_view[CSO_RX_BUSY_BIT] = rx_st_q != RX_IDLE;
		stat_view[CSO_TX_BUSY_BIT] = tx_act_q;
	end

	// One wait state: answer at the second edge of a request
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	// Registered so read data stands through the answer cycle
	assign avs_readdata = rdata_q;

	always_comb begin
		ack_d = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		rx_en_d = rx_en_q;
		rx_mode_d = rx_mode_q;
		tx_en_d = tx_en_q;
		if (avs_read && !ack_q) begin
			if (hit_ctrl)
				rdata_d = ctrl_view;
			else if (hit_stat)
				rdata_d = stat_view;
			else
				rdata_d = CSO_READ_UNMAPPED;
		end
		// Mode changes take effect at once, enables only at the next sof; software must wait for idle paths
		if (avs_write && ack_q && hit_ctrl) begin
			if (avs_byteenable[0]) begin
				rx_en_d = avs_writedata[CSO_RX_EN_BIT];
				rx_mode_d = avs_writedata[CSO_RX_MODE_BIT];
			end
			if (avs_byteenable[2])
				tx_en_d = avs_writedata[CSO_TX_EN_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rx_en_q <= CSO_EN_RESET;
			rx_mode_q <= CSO_MODE_RESET;
			tx_en_q <= CSO_EN_RESET;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			rx_en_q <= rx_en_d;
			rx_mode_q <= rx_mode_d;
			tx_en_q <= tx_en_d;
		end
	end

	// Receive start finder and summer
	// A new start of frame restarts the walk when rx_en_q is set, even mid-frame; with it clear the walk drops to idle
	always_comb begin
		logic [15:0] rtype;
		logic [15:0] acc_n;
		logic        summing;
		rtype = {rx_hi_q, rx_in.data};
		acc_n = rx_acc_q;
		summing = 1'b0;
		rx_st_d = rx_st_q;
		rx_cnt_d = rx_cnt_q;
		rx_hi_d = rx_hi_q;
		rx_acc_d = rx_acc_q;
		rx_odd_d = rx_odd_q;
		rx_snap_d = rx_snap_q;
		rx_csum_d = '{valid: 1'b0, sum: rx_csum_q.sum};
		if (rx_in.valid) begin
			if (rx_in.sof) begin
				// Disabled engine never leaves idle
				rx_st_d = rx_en_q ? RX_ADDR : RX_IDLE;
				rx_cnt_d = 4'h1;
				rx_acc_d = 16'h0000;
				rx_odd_d = 1'b0;
			end else begin
				case (rx_st_q)
					RX_ADDR: begin
						if (rx_cnt_q == CSO_ADDR_BYTES - 4'h1)
							rx_st_d = RX_TYPE_HI;
						else
							rx_cnt_d = rx_cnt_q + 4'h1;
					end
					RX_TYPE_HI: begin
						rx_hi_d = rx_in.data;
						rx_st_d = RX_TYPE_LO;
					end
					RX_TYPE_LO: begin
						// Mode one comes back here after every tag
						rx_cnt_d = 4'h0;
						if (!rx_mode_q) begin
							rx_st_d = RX_SUM;
						end else if (rtype == CSO_TYPE_VLAN ||
							rtype == CSO_TYPE_QINQ) begin
							rx_st_d = RX_TAG;
						end else if (rtype <= CSO_MAX_LENGTH) begin
							rx_st_d = RX_SNAP;
							rx_snap_d = 1'b1;
						end else begin
							rx_st_d = RX_SUM;
						end
					end
					RX_TAG: begin
						// Tag control word, then the next type field
						if (rx_cnt_q == CSO_TAG_BYTES - 4'h1)
							rx_st_d = RX_TYPE_HI;
						else
							rx_cnt_d = rx_cnt_q + 4'h1;
					end
					RX_SNAP: begin
						// Summed meanwhile, in case it is plain LLC
						summing = 1'b1;
						if ((rx_cnt_q < 4'h2 && rx_in.data != CSO_LLC_SAP) ||
							(rx_cnt_q == 4'h2 && rx_in.data != CSO_LLC_CTRL))
							rx_snap_d = 1'b0;
					end
					RX_SUM: begin
						summing = 1'b1;
					end
					default: begin
						rx_st_d = RX_IDLE;
					end
				endcase
				if (summing) begin
					acc_n = cso_add_byte(rx_acc_q, rx_odd_q, rx_in.data);
					rx_acc_d = acc_n;
					rx_odd_d = ~rx_odd_q;
				end
				if (rx_st_q == RX_SNAP) begin
					if (rx_cnt_q == CSO_SNAP_BYTES - 4'h1) begin
						rx_st_d = RX_SUM;
						// SNAP confirmed: sum restarts
						if (rx_snap_d) begin
							rx_acc_d = 16'h0000;
							rx_odd_d = 1'b0;
						end
					end else begin
						rx_cnt_d = rx_cnt_q + 4'h1;
					end
				end
				if (rx_in.eof && rx_st_q != RX_IDLE) begin
					rx_st_d = RX_IDLE;
					rx_csum_d = '{valid: 1'b1, sum: acc_n};
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_hi_q <= 8'h00;
			rx_acc_q <= 16'h0000;
			rx_odd_q <= 1'b0;
			rx_snap_q <= 1'b0;
			rx_out_q <= '0;
			rx_csum_q <= '0;
		end else begin
			rx_st_q <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_hi_q <= rx_hi_d;
			rx_acc_q <= rx_acc_d;
			rx_odd_q <= rx_odd_d;
			rx_snap_q <= rx_snap_d;
			rx_out_q <= rx_in;
			rx_csum_q <= rx_csum_d;
		end
	end

	// Transmit summer, fixed start after the Ethernet header
	// No back-pressure: a byte is taken on every valid cycle
	always_comb begin
		logic [15:0] acc_n;
		acc_n = tx_acc_q;
		tx_act_d = tx_act_q;
		tx_cnt_d = tx_cnt_q;
		tx_acc_d = tx_acc_q;
		tx_odd_d = tx_odd_q;
		tx_csum_d = '{valid: 1'b0, sum: tx_csum_q.sum};
		if (tx_in.valid) begin
			if (tx_in.sof) begin
				tx_act_d = tx_en_q;
				tx_cnt_d = 4'h1;
				tx_acc_d = 16'h0000;
				tx_odd_d = 1'b0;
			end else if (tx_act_q) begin
				if (tx_cnt_q == CSO_HDR_BYTES) begin
					acc_n = cso_add_byte(tx_acc_q, tx_odd_q, tx_in.data);
					tx_acc_d = acc_n;
					tx_odd_d = ~tx_odd_q;
				end else begin
					tx_cnt_d = tx_cnt_q + 4'h1;
				end
				if (tx_in.eof) begin
					tx_act_d = 1'b0;
					tx_csum_d = '{valid: 1'b1, sum: acc_n};
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_act_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			tx_acc_q <= 16'h0000;
			tx_odd_q <= 1'b0;
			tx_out_q <= '0;
			tx_csum_q <= '0;
		end else begin
			tx_act_q <= tx_act_d;
			tx_cnt_q <= tx_cnt_d;
			tx_acc_q <= tx_acc_d;
			tx_odd_q <= tx_odd_d;
			tx_out_q <= tx_in;
			tx_csum_q <= tx_csum_d;
		end
	end

	// Frames pass unchanged with one cycle of latency either way
	// Sums come out uninverted; the consumer complements them
	assign rx_out = rx_out_q;
	assign rx_csum = rx_csum_q;
	assign tx_out = tx_out_q;
	assign tx_csum = tx_csum_q;

endmodule
`default_nettype wire

/* File: sim/cso_ctrl_asserts.sv */
`default_nettype none
module cso_ctrl_asserts
	import cso_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire cso_byte_s   rx_in,
	input wire cso_byte_s   rx_out,
	input wire cso_csum_s   rx_csum,
	input wire cso_byte_s   tx_in,
	input wire cso_byte_s   tx_out,
	input wire cso_csum_s   tx_csum
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence rd_done(idx);
		avs_read && !avs_waitrequest && avs_address[7:2] == idx;
	endsequence
	a_reserved_reads_zero: assert property (
		rd_done(CSO_CTRL_IDX) |-> (avs_readdata & 32'hfffe_fffc) == 32'h0)
		else $error("reserved control bit reads one");
	a_rx_stream_passes: assert property (
		!rst |=> rx_out == $past(rx_in))
		else $error("receive stream altered");
	a_tx_stream_passes: assert property (
		!rst |=> tx_out == $past(tx_in))
		else $error("transmit stream altered");
	a_rx_sum_timing: assert property (
		rx_csum.valid |-> $past(rx_in.valid && rx_in.eof))
		else $error("receive sum not one cycle after last byte");
	a_tx_sum_timing: assert property (
		tx_csum.valid |-> $past(tx_in.valid && tx_in.eof))
		else $error("transmit sum not one cycle after last byte");
endmodule
bind cso_checksum_offload_control cso_ctrl_asserts u_chk (.*);
`default_nettype wire

/* File: sim/cso_mac_model.sv */
`default_nettype none
module cso_mac_model
	import cso_pkg::*;
(
	input wire logic      core_clk,
	output var cso_byte_s strm
);
	timeunit 1ns;
	timeprecision 1ps;
	initial strm = '0;
	// Frames only when the bench allows, never mid-setting change
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			@(posedge core_clk);
			strm <= '{1'b1, i == 0, i == f.size() - 1, f[i]};
		end
		@(posedge core_clk);
		// Idle data flips so a stale byte is never mistaken for live
		strm <= '{1'b0, 1'b0, 1'b0, ~f[f.size() - 1]};
	endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb
	import cso_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata, q;
	logic        avs_waitrequest;
	cso_byte_s   rx_in, rx_out, tx_in, tx_out;
	cso_csum_s   rx_csum, tx_csum;
	int          miscompares = 0;
	int          checks = 0;
	int          rx_n, tx_n;
	logic [15:0] rx_s, tx_s;
	logic [31:0] lfsr = 32'h099c;
	logic [7:0]  fr[$], ft[$];
	always #5 core_clk = ~core_clk;
	cso_checksum_offload_control u_dut (.*);
	cso_mac_model u_rxm (.core_clk(core_clk), .strm(rx_in));
	cso_mac_model u_txm (.core_clk(core_clk), .strm(tx_in));
	function automatic logic [7:0] rnd8();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction
	function automatic logic [15:0] exp_sum(input logic [7:0] f[$], int s);
		logic [16:0] a;
		a = 17'h0;
		for (int i = s; i < f.size(); i++) begin
			a = a + ((i - s) % 2 ? {9'h0, f[i]} : {1'b0, f[i], 8'h00});
			a = a[15:0] + a[16];
		end
		return a[15:0];
	endfunction
	function automatic int start_of(input logic [7:0] f[$], logic m);
		int s;
		s = 12;
		while (m && ({f[s], f[s + 1]} == CSO_TYPE_VLAN ||
			{f[s], f[s + 1]} == CSO_TYPE_QINQ))
			s += 4;
		if (m && {f[s], f[s + 1]} <= CSO_MAX_LENGTH && f[s + 2] == CSO_LLC_SAP
			&& f[s + 3] == CSO_LLC_SAP && f[s + 4] == CSO_LLC_CTRL)
			s += 8;
		return s + 2;
	endfunction
	task automatic mk(output logic [7:0] f[$], input int k);
		f = {};
		repeat (12) f.push_back(rnd8());
		case (k % 4)
			0: f = {f, 8'h08, 8'h00};
			1: f = {f, 8'h81, 8'h00, rnd8(), rnd8(), 8'h08, 8'h00};
			2: f = {f, 8'h88, 8'ha8, rnd8(), rnd8(), 8'h81, 8'h00, rnd8(),
				rnd8(), 8'h08, 8'h00};
			default: f = {f, 8'h00, 8'h40, 8'haa, 8'haa, 8'h03, 8'h00,
				8'h00, 8'h00, 8'h08, 8'h00};
		endcase
		repeat (20 + rnd8() % 21) f.push_back(rnd8());
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic wr, logic [7:0] a, logic [31:0] d,
		logic [3:0] be, output logic [31:0] rd);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		// Waits as long as the slave asks; only the watchdog ends a hang
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (rx_csum.valid === 1'b1) begin
			rx_n++;
			rx_s = rx_csum.sum;
		end
		if (tx_csum.valid === 1'b1) begin
			tx_n++;
			tx_s = tx_csum.sum;
		end
	end
	initial begin
		#100us;
		miscompares++;
		results();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		bus(1'b0, 8'h34, 32'h0, 4'hf, q);
		chk(q, 32'h0);
		// Lane 2 off: bit 16 must stay clear
		bus(1'b1, 8'h34, 32'hffff_ffff, 4'hb, q);
		bus(1'b0, 8'h34, 32'h0, 4'hf, q);
		chk(q, 32'h3);
		bus(1'b1, 8'h3c, 32'hffff_ffff, 4'hf, q);
		bus(1'b0, 8'h3c, 32'h0, 4'hf, q);
		chk(q, CSO_READ_UNMAPPED);
		bus(1'b0, 8'h34, 32'h0, 4'hf, q);
		chk(q, 32'h3);
		$display("register test done");
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, 8'h34, {15'h0, i[2], 14'h0, i[1:0]}, 4'hf, q);
			bus(1'b0, 8'h34, 32'h0, 4'hf, q);
			chk(q, {15'h0, i[2], 14'h0, i[1:0]});
			mk(fr, i >> 2);
			mk(ft, i);
			rx_n = 0;
			tx_n = 0;
			fork
				u_rxm.send(fr);
				u_txm.send(ft);
				begin
					// Mid-frame: busy bits follow the enables taken at sof
					repeat (20) @(posedge core_clk);
					bus(1'b0, 8'h38, 32'h0, 4'hf, q);
					chk(q, {30'h0, i[2], i[0]});
				end
			join
			repeat (3) @(posedge core_clk);
			chk(rx_n, i[0]);
			chk(tx_n, i[2]);
			if (i[0]) chk(rx_s, exp_sum(fr, start_of(fr, i[1])));
			if (i[2]) chk(tx_s, exp_sum(ft, 14));
			$display("frame test %0d done", i);
		end
		// Reset mid-run must clear every control bit again
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		bus(1'b0, 8'h34, 32'h0, 4'hf, q);
		chk(q, 32'h0);
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
